// *** design/cspg_pulse_gen.sv ***
// Comparator-synchronised pulse generator with AHB-Lite register access.
// Assumes comparator outputs and the surge signal arrive as asynchronous levels.
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps

module cspg_pulse_gen
  import cspg_pkg::*;
#(
  parameter bit INVERT_PULSE = 1'b0
) (
  // Clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_NRST,
  // AHB-Lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // Analog front end, bit 0 is comparator 1
  input  wire logic [7:0]  I_CMP,
  input  wire logic        I_SURGE,
  // Pins
  output logic             O_PULSE_OUT_PIN,
  output logic             O_PULSE_OUT_PIN_OE_N,
  output logic             O_MONITOR_PIN,
  output logic             O_COMPARATOR_ROUTE_PIN
);

  // Bus state.
  logic              wr_pend;
  logic [7:0]        wr_addr;
  logic              acc_valid;
  logic              wr_now;

  // Software registers.
  logic [CR_W-1:0]    ctrl_one;
  logic [CR2_W-1:0]   ctrl_two;
  logic [DLY_W-1:0]   delay_set;
  logic [ON_W-1:0]    on_a;
  logic [ON_W-1:0]    on_b;
  logic [CR345_W-1:0] ctrl_three;
  logic [CR345_W-1:0] ctrl_four;
  logic [CR345_W-1:0] ctrl_five;
  logic [BLK1_W-1:0]  blank_one_set;
  logic [TOT_W-1:0]   timeout_set;
  logic [BLK38_W-1:0] blank_three_set;
  logic [BLK38_W-1:0] blank_eight_set;
  logic               cap_sel_sw;

  // Working buffers and core state.
  logic [DLY_W-1:0]   delay_buf;
  logic [ON_W-1:0]    on_buf;
  logic [BLK1_W-1:0]  blank_one_buf;
  logic [TOT_W-1:0]   timeout_buf;
  logic [BLK38_W-1:0] blank_three_buf;
  logic [BLK38_W-1:0] blank_eight_buf;
  logic               cap_sel_buf;
  logic [ON_W-1:0]    capture;
  logic [CNT_W-1:0]   cnt;
  cspg_phase_t        phase;
  logic               pulse;
  logic               run_d;
  logic               mode_lat;
  logic               blank_one;
  logic               blank_three;
  logic               blank_eight;
  logic               c2_acc;

  // Synchronisers.
  logic [8:0]         sync_a;
  logic [8:0]         sync_b;
  logic [8:0]         sync_c;

  logic               gen_en;
  logic               run;
  logic               run_rise;
  logic               cmp1_fall;
  logic               cmp2_rise;
  logic               cmp7_rise;
  logic               surge_hit;
  logic               cmp3_high;
  logic               cmp8_high;
  logic               delay_match;
  logic               on_match;
  logic               timeout_hit;
  logic               sync_flag;
  logic [DLY_W-1:0]   delay_eff;
  logic [ON_W-1:0]    on_eff;
  logic [ON_W-1:0]    next_on_buf;

  assign gen_en = ctrl_one[BIT_GEN_ENABLE];
  assign run    = ctrl_one[BIT_PULSE_RUN];

  // AHB-Lite: zero wait states, always OKAY.
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  assign acc_valid   = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign wr_now      = wr_pend & I_HREADY;

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      wr_pend <= 1'b0;
      wr_addr <= RST_BYTE;
    end else if (I_HREADY) begin
      wr_pend <= acc_valid & I_HWRITE;
      wr_addr <= {I_HADDR[7:2], 2'b00};
    end
  end

  // Read data is taken in the address phase so it stands from a flop in the data phase.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (acc_valid && !I_HWRITE) begin
      unique case ({I_HADDR[7:2], 2'b00})
        ADDR_CTRL_ONE:   O_HRDATA <= {24'h00_0000, ctrl_one};
        ADDR_CTRL_TWO:   O_HRDATA <= {25'h000_0000, ctrl_two};
        ADDR_DELAY:      O_HRDATA <= {24'h00_0000, delay_set};
        ADDR_ON_TIME_A:  O_HRDATA <= {21'h00_0000, on_a};
        ADDR_ON_TIME_B:  O_HRDATA <= {21'h00_0000, on_b};
        ADDR_CAPTURE:    O_HRDATA <= {16'h0000, cap_sel_sw, 4'h0, capture};
        ADDR_CTRL_THREE: O_HRDATA <= {26'h000_0000, ctrl_three};
        ADDR_CTRL_FOUR:  O_HRDATA <= {26'h000_0000, ctrl_four};
        ADDR_CTRL_FIVE:  O_HRDATA <= {26'h000_0000, ctrl_five};
        ADDR_BLANK_ONE:  O_HRDATA <= {24'h00_0000, blank_one_set};
        ADDR_TIMEOUT:    O_HRDATA <= {24'h00_0000, timeout_set};
        ADDR_BLANK_THR:  O_HRDATA <= {26'h000_0000, blank_three_set};
        ADDR_BLANK_EGT:  O_HRDATA <= {26'h000_0000, blank_eight_set};
        default:         O_HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Plain setting registers.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_two        <= RST_BYTE[CR2_W-1:0];
      delay_set       <= RST_BYTE;
      on_a            <= RST_ON_TIME;
      on_b            <= RST_ON_TIME;
      ctrl_three      <= RST_BYTE[CR345_W-1:0];
      ctrl_four       <= RST_BYTE[CR345_W-1:0];
      ctrl_five       <= RST_BYTE[CR345_W-1:0];
      blank_one_set   <= RST_BYTE;
      timeout_set     <= RST_BYTE;
      blank_three_set <= RST_BYTE[BLK38_W-1:0];
      blank_eight_set <= RST_BYTE[BLK38_W-1:0];
      cap_sel_sw      <= 1'b0;
    end else if (wr_now) begin
      unique case (wr_addr)
        ADDR_CTRL_TWO:   ctrl_two        <= I_HWDATA[CR2_W-1:0];
        ADDR_DELAY:      delay_set       <= I_HWDATA[DLY_W-1:0];
        ADDR_ON_TIME_A:  on_a            <= I_HWDATA[ON_W-1:0];
        ADDR_ON_TIME_B:  on_b            <= I_HWDATA[ON_W-1:0];
        ADDR_CAPTURE:    cap_sel_sw      <= I_HWDATA[BIT_CAPTURE_SEL];
        ADDR_CTRL_THREE: ctrl_three      <= I_HWDATA[CR345_W-1:0];
        ADDR_CTRL_FOUR:  ctrl_four       <= I_HWDATA[CR345_W-1:0];
        ADDR_CTRL_FIVE:  ctrl_five       <= I_HWDATA[CR345_W-1:0];
        ADDR_BLANK_ONE:  blank_one_set   <= I_HWDATA[BLK1_W-1:0];
        ADDR_TIMEOUT:    timeout_set     <= I_HWDATA[TOT_W-1:0];
        ADDR_BLANK_THR:  blank_three_set <= I_HWDATA[BLK38_W-1:0];
        ADDR_BLANK_EGT:  blank_eight_set <= I_HWDATA[BLK38_W-1:0];
        default: ;
      endcase
    end
  end

  // Two-stage synchronisers; the third stage exists only for edge detection.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
      sync_c <= 9'h000;
    end else begin
      sync_a <= {I_SURGE, I_CMP};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign cmp1_fall = ~sync_b[0] & sync_c[0];
  assign cmp2_rise = sync_b[1] & ~sync_c[1];
  assign cmp7_rise = sync_b[6] & ~sync_c[6];
  assign surge_hit = sync_b[8] & ctrl_one[BIT_SURGE_ENABLE];
  assign cmp3_high = sync_b[2] & ~blank_three & run;
  assign cmp8_high = sync_b[7] & ~blank_eight & run;

  // Control register one: hardware sets win over software writes, and a
  // hardware stop beats a software start so that a fault cannot be overridden.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_one <= RST_BYTE;
    end else begin
      if (wr_now && wr_addr == ADDR_CTRL_ONE) begin
        ctrl_one[BIT_GEN_ENABLE]   <= I_HWDATA[BIT_GEN_ENABLE];
        ctrl_one[BIT_PULSE_RUN]    <= I_HWDATA[BIT_PULSE_RUN];
        ctrl_one[BIT_REPEAT_MODE]  <= I_HWDATA[BIT_REPEAT_MODE];
        ctrl_one[BIT_SURGE_ENABLE] <= I_HWDATA[BIT_SURGE_ENABLE];
        ctrl_one[BIT_ON_TIME_SEL]  <= I_HWDATA[BIT_ON_TIME_SEL];
        ctrl_one[BIT_SURGE_FLAG]   <= I_HWDATA[BIT_SURGE_FLAG];
        ctrl_one[BIT_SURGE_IRQ_EN] <= I_HWDATA[BIT_SURGE_IRQ_EN];
      end
      if (gen_en && cmp2_rise) begin
        ctrl_one[BIT_ON_TIME_SEL] <= 1'b1;
      end
      if (gen_en && surge_hit) begin
        ctrl_one[BIT_SURGE_FLAG] <= 1'b1;
      end
      if (surge_hit || (gen_en && cmp7_rise)) begin
        ctrl_one[BIT_PULSE_RUN] <= 1'b0;
      end
      if (gen_en && run && cmp1_fall) begin
        ctrl_one[BIT_CMP2_HISTORY] <= c2_acc | cmp2_rise;
      end
    end
  end

  // Comparator 2 rising edges seen since the last comparator 1 falling edge.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      c2_acc <= 1'b0;
    end else if (gen_en && run && cmp1_fall) begin
      c2_acc <= 1'b0;
    end else if (gen_en && run && cmp2_rise) begin
      c2_acc <= 1'b1;
    end
  end

  // Start detection and repeat-mode latch.
  assign run_rise = run & ~run_d;

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      run_d    <= 1'b0;
      mode_lat <= 1'b0;
    end else begin
      run_d <= run;
      if (run_rise) begin
        mode_lat <= ctrl_one[BIT_REPEAT_MODE];
      end
    end
  end

  // Matches. A zero delay or on-time setting is treated as one.
  assign delay_eff   = (delay_buf == '0) ? DLY_W'(1) : delay_buf;
  assign on_eff      = (on_buf == '0) ? ON_W'(1) : on_buf;
  assign delay_match = run && phase == PH_DELAY && cnt == CNT_W'(delay_eff);
  assign on_match    = run && phase == PH_ON && cnt == CNT_W'(on_eff);
  assign timeout_hit = run && mode_lat && phase == PH_WAIT && cnt == CNT_W'(timeout_buf);

  // Sync flag: start always, edge and timeout only in repeat mode.
  assign sync_flag = run_rise
                   | (run && mode_lat && ((cmp1_fall && !blank_one) || timeout_hit));

  assign next_on_buf = ctrl_one[BIT_ON_TIME_SEL] ? on_b : on_a;

  // Match buffers reload only on the sync flag, so writes act at the next cycle start.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      delay_buf       <= RST_BYTE;
      on_buf          <= RST_ON_TIME;
      blank_one_buf   <= RST_BYTE;
      timeout_buf     <= RST_BYTE;
      blank_three_buf <= RST_BYTE[BLK38_W-1:0];
      blank_eight_buf <= RST_BYTE[BLK38_W-1:0];
      cap_sel_buf     <= 1'b0;
    end else if (sync_flag) begin
      delay_buf       <= delay_set;
      on_buf          <= next_on_buf;
      blank_one_buf   <= blank_one_set;
      timeout_buf     <= timeout_set;
      blank_three_buf <= blank_three_set;
      blank_eight_buf <= blank_eight_set;
      cap_sel_buf     <= cap_sel_sw;
    end
  end

  // Blanking windows open at sync and close on the first counter match.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      blank_one   <= 1'b0;
      blank_three <= 1'b0;
      blank_eight <= 1'b0;
    end else if (sync_flag) begin
      blank_one   <= 1'b1;
      blank_three <= 1'b1;
      blank_eight <= 1'b1;
    end else begin
      if (cnt == CNT_W'(blank_one_buf)) begin
        blank_one <= 1'b0;
      end
      if (cnt == CNT_W'(blank_three_buf)) begin
        blank_three <= 1'b0;
      end
      if (cnt == CNT_W'(blank_eight_buf)) begin
        blank_eight <= 1'b0;
      end
    end
  end

  // 12-bit counter.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      cnt <= '0;
    end else if (sync_flag || delay_match || on_match) begin
      cnt <= '0;
    end else if (run) begin
      cnt <= cnt + CNT_W'(CNT_STEP);
    end
  end

  // Phase sequencing.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      phase <= PH_IDLE;
    end else if (!run) begin
      phase <= PH_IDLE;
    end else if (sync_flag) begin
      phase <= PH_DELAY;
    end else if (delay_match) begin
      phase <= PH_ON;
    end else if (on_match || (cmp3_high && phase == PH_ON)) begin
      phase <= mode_lat ? PH_WAIT : PH_IDLE;
    end
  end

  // Pulse output state.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pulse <= 1'b0;
    end else if (!run) begin
      pulse <= 1'b0;
    end else if (cmp3_high) begin
      pulse <= 1'b0;
    end else if (on_match) begin
      pulse <= 1'b0;
    end else if (delay_match) begin
      pulse <= 1'b1;
    end
  end

  // On-time capture while the pulse is on.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      capture <= RST_ON_TIME;
    end else if (phase == PH_ON && (cap_sel_buf ? cmp8_high : cmp3_high)) begin
      capture <= cnt[ON_W-1:0];
    end
  end

  // Pins, registered so the pin data comes from flops.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PULSE_OUT_PIN        <= INVERT_PULSE;
      O_PULSE_OUT_PIN_OE_N   <= 1'b1;
      O_MONITOR_PIN          <= 1'b0;
      O_COMPARATOR_ROUTE_PIN <= 1'b0;
    end else begin
      O_PULSE_OUT_PIN        <= pulse ^ INVERT_PULSE;
      O_PULSE_OUT_PIN_OE_N   <= ~gen_en;
      O_MONITOR_PIN          <= ctrl_two[BIT_MONITOR_EN] & (pulse ^ INVERT_PULSE);
      O_COMPARATOR_ROUTE_PIN <= ctrl_two[BIT_ROUTE_EN] & sync_b[ctrl_two[BIT_ROUTE_SEL_LSB +: 3]];
    end
  end

endmodule

// *** design/cspg_pkg.sv ***
// Package for the comparator-synchronised pulse generator.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package cspg_pkg;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] ADDR_CTRL_ONE   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO   = 8'h04;
  localparam logic [7:0] ADDR_DELAY      = 8'h08;
  localparam logic [7:0] ADDR_ON_TIME_A  = 8'h0C;
  localparam logic [7:0] ADDR_ON_TIME_B  = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE    = 8'h14;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h18;
  localparam logic [7:0] ADDR_CTRL_FOUR  = 8'h1C;
  localparam logic [7:0] ADDR_CTRL_FIVE  = 8'h20;
  localparam logic [7:0] ADDR_BLANK_ONE  = 8'h24;
  localparam logic [7:0] ADDR_TIMEOUT    = 8'h28;
  localparam logic [7:0] ADDR_BLANK_THR  = 8'h2C;
  localparam logic [7:0] ADDR_BLANK_EGT  = 8'h30;

  // Field positions in control register one.
  localparam int BIT_GEN_ENABLE   = 7;
  localparam int BIT_PULSE_RUN    = 6;
  localparam int BIT_REPEAT_MODE  = 5;
  localparam int BIT_SURGE_ENABLE = 4;
  localparam int BIT_ON_TIME_SEL  = 3;
  localparam int BIT_CMP2_HISTORY = 2;
  localparam int BIT_SURGE_FLAG   = 1;
  localparam int BIT_SURGE_IRQ_EN = 0;

  // Field positions in control register two.
  localparam int BIT_ROUTE_SEL_LSB = 4;
  localparam int BIT_MONITOR_EN    = 3;
  localparam int BIT_ROUTE_EN      = 2;

  // Capture trigger select sits in bit 7 of the capture high byte.
  localparam int BIT_CAPTURE_SEL = 15;

  // Widths.
  localparam int CNT_W   = 12;
  localparam int DLY_W   = 8;
  localparam int ON_W    = 11;
  localparam int BLK1_W  = 8;
  localparam int TOT_W   = 8;
  localparam int BLK38_W = 6;
  localparam int CR_W    = 8;
  localparam int CR2_W   = 7;
  localparam int CR345_W = 6;

  // Reset values.
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [10:0] RST_ON_TIME = 11'h000;

  // Timing: the count clock is the system clock.
  localparam int CLK_FREQ_MHZ = 25;
  localparam int CNT_STEP     = 1;

  typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_ON, PH_WAIT} cspg_phase_t;

endpackage

// *** test/cspg_pulse_gen_asserts.sv ***
// Checker for the pulse generator, watching only the ports of its top module.
// Assumes one clock domain and register writes that take effect at the data-phase edge.
`timescale 1ns/10ps
module cspg_pulse_gen_asserts
  import cspg_pkg::*;
#(
  parameter bit INVERT_PULSE = 1'b0
) (
  // Clock and reset
  input wire logic        I_CLK_SYS,
  input wire logic        I_NRST,
  // Bus
  input wire logic        I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0]  I_HTRANS,
  input wire logic        I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic        I_HREADY,
  input wire logic        O_HREADYOUT,
  input wire logic        O_HRESP,
  // Pins
  input wire logic [7:0]  I_CMP,
  input wire logic        O_PULSE_OUT_PIN,
  input wire logic        O_PULSE_OUT_PIN_OE_N,
  input wire logic        O_MONITOR_PIN,
  input wire logic        O_COMPARATOR_ROUTE_PIN
);
  logic       wr_pend, wr_ctl, en, run_w, single, ever_run, pulse, pulse_q, quiet;
  logic [7:0] wr_addr, prev_cmp;
  logic [6:0] cr2, prev_cr2;
  logic [3:0] rises;

  assign pulse  = O_PULSE_OUT_PIN ^ INVERT_PULSE;
  assign wr_ctl = wr_pend && I_HREADY && (wr_addr == ADDR_CTRL_ONE);

  // Software view of the control bits; hardware clears are not tracked, so only safe relations use them.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      wr_pend  <= 1'b0;
      wr_addr  <= 8'h00;
      en       <= 1'b0;
      run_w    <= 1'b0;
      single   <= 1'b0;
      ever_run <= 1'b0;
      cr2      <= 7'h00;
      rises    <= 4'h0;
    end else begin
      wr_pend <= I_HSEL && I_HTRANS[1] && I_HWRITE && I_HREADY;
      wr_addr <= I_HADDR[7:0];
      if (wr_ctl) begin
        en       <= I_HWDATA[BIT_GEN_ENABLE];
        run_w    <= I_HWDATA[BIT_PULSE_RUN];
        ever_run <= ever_run | I_HWDATA[BIT_PULSE_RUN];
      end
      if (wr_ctl && I_HWDATA[BIT_PULSE_RUN] && !run_w) begin
        single <= !I_HWDATA[BIT_REPEAT_MODE];
        rises  <= 4'h0;
      end else if (pulse && !pulse_q && rises != 4'hF) begin
        rises <= rises + 4'h1;
      end
      if (wr_pend && I_HREADY && (wr_addr == ADDR_CTRL_TWO)) begin
        cr2 <= I_HWDATA[6:0];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      pulse_q  <= 1'b0;
      prev_cmp <= 8'h00;
      prev_cr2 <= 7'h00;
      quiet    <= 1'b0;
    end else begin
      pulse_q  <= pulse;
      prev_cmp <= I_CMP;
      prev_cr2 <= cr2;
      quiet    <= (I_CMP == prev_cmp) && (cr2 == prev_cr2);
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);

  AST_READY_ALWAYS: assert property (O_HREADYOUT)
    else $error("bus slave inserted a wait state");
  AST_RESP_OKAY: assert property (!O_HRESP)
    else $error("bus slave answered with an error response");
  AST_OE_TRACKS_ENABLE: assert property (O_PULSE_OUT_PIN_OE_N == !$past(en))
    else $error("pulse pin drive does not follow the enable bit");
  AST_IDLE_BEFORE_RUN: assert property (!ever_run |-> O_PULSE_OUT_PIN == INVERT_PULSE)
    else $error("pulse active before the generator was ever started");
  AST_SINGLE_SHOT: assert property (single |-> rises <= 4'h1)
    else $error("more than one pulse without repeat mode");
  AST_ROUTE_OFF: assert property (!$past(cr2[2]) |-> !O_COMPARATOR_ROUTE_PIN)
    else $error("route pin active while routing is off");
  AST_ROUTE_FOLLOWS: assert property (quiet [*5] |->
                                      O_COMPARATOR_ROUTE_PIN == (prev_cr2[2] & prev_cmp[prev_cr2[6:4]]))
    else $error("route pin does not show the chosen comparator");
  AST_MONITOR_COPY: assert property (O_MONITOR_PIN == ($past(cr2[3]) && pulse))
    else $error("monitor pin does not copy the pulse");
endmodule

bind cspg_pulse_gen cspg_pulse_gen_asserts #(.INVERT_PULSE(INVERT_PULSE)) u_asserts (
  .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
  .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HREADYOUT(O_HREADYOUT),
  .O_HRESP(O_HRESP), .I_CMP(I_CMP), .O_PULSE_OUT_PIN(O_PULSE_OUT_PIN),
  .O_PULSE_OUT_PIN_OE_N(O_PULSE_OUT_PIN_OE_N), .O_MONITOR_PIN(O_MONITOR_PIN),
  .O_COMPARATOR_ROUTE_PIN(O_COMPARATOR_ROUTE_PIN)
);

// *** test/cspg_cmp_model.sv ***
// Model of the comparator bank and surge detector feeding the pulse generator.
// Assumes the bench commands the levels; a lag of up to 15 cycles models a slow front end.
`timescale 1ns/10ps
module cspg_cmp_model (
  // Clock and command
  input  wire logic       i_clk,
  input  wire logic [3:0] i_lag,
  input  wire logic [8:0] i_cmd,
  // Levels, bit 8 is the surge detector
  output logic      [8:0] o_lvl
);
  logic [8:0] pipe [16];

  always_ff @(posedge i_clk) begin
    pipe[0] <= i_cmd;
    for (int k = 1; k < 16; k++) begin
      pipe[k] <= pipe[k - 1];
    end
  end

  assign o_lvl = (i_lag == 4'h0) ? i_cmd : pipe[i_lag - 4'h1];
endmodule

// *** test/tb.sv ***
// Bench for the pulse generator: registers, pulse timing and comparator reactions.
// Assumes one AHB-Lite master here and the comparator bank model on the analog inputs.
`timescale 1ns/10ps
module tb;
  import cspg_pkg::*;
  localparam logic [31:0] GO  = 32'h0000_00C0;
  localparam logic [31:0] EN  = 32'h0000_0080;
  localparam logic [31:0] REP = 32'h0000_0020;
  logic        clk, nrst, hsel, hwrite, rdy, resp, pin, oe_n, mon, route;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [8:0]  cmd, lvl;
  logic [3:0]  lag;
  int          failures, n_checks, nrise, base, lat, lat1, wid;
  logic [7:0]  ra [12] = '{ADDR_CTRL_TWO, ADDR_DELAY, ADDR_ON_TIME_A, ADDR_ON_TIME_B, ADDR_CAPTURE,
                           ADDR_CTRL_THREE, ADDR_CTRL_FOUR, ADDR_CTRL_FIVE, ADDR_BLANK_ONE, ADDR_TIMEOUT,
                           ADDR_BLANK_THR, ADDR_BLANK_EGT};
  logic [15:0] rm [12] = '{16'h007F, 16'h00FF, 16'h07FF, 16'h07FF, 16'h8000, 16'h003F, 16'h003F,
                           16'h003F, 16'h00FF, 16'h00FF, 16'h003F, 16'h003F};

  cspg_pulse_gen uut (
    .I_CLK_SYS(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(rdy), .O_HRDATA(hrdata), .O_HREADYOUT(rdy), .O_HRESP(resp),
    .I_CMP(lvl[7:0]), .I_SURGE(lvl[8]), .O_PULSE_OUT_PIN(pin), .O_PULSE_OUT_PIN_OE_N(oe_n),
    .O_MONITOR_PIN(mon), .O_COMPARATOR_ROUTE_PIN(route)
  );
  cspg_cmp_model u_cmp (.i_clk(clk), .i_lag(lag), .i_cmd(cmd), .o_lvl(lvl));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // The pin is registered, so its rising edges are clean pulse starts.
  always @(posedge pin) nrise++;

  task conclude();
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk); while (rdy !== 1'h1);
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'h1, a, v, d);
  endtask

  // Presets the delay, starts, rewrites the delay mid-run, and raises kick for three cycles at on-cycle kt.
  task pulse(input logic [31:0] ctl, input logic [7:0] d1, input logic [7:0] d2, input logic [8:0] kick,
             input int kt, output int lt, output int w);
    wr(ADDR_DELAY, {24'h00_0000, d1});
    wr(ADDR_CTRL_ONE, ctl);
    wr(ADDR_DELAY, {24'h00_0000, d2});
    lt = 0;
    while (pin !== 1'h1 && lt < 600) begin
      @(posedge clk);
      lt++;
    end
    w = 0;
    while (pin !== 1'h0 && w < 3000) begin
      @(posedge clk);
      w++;
      if (w == kt) cmd <= kick;
      if (w == kt + 3) cmd <= 9'h000;
    end
    cyc(1);
    cmd <= 9'h000;
    wr(ADDR_CTRL_ONE, EN);
    cyc(3);
    chk({31'h0, pin}, 32'h0);
  endtask

  initial begin
    nrst = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hwdata = 32'h0000_0000;
    cmd = 9'h000;
    lag = 4'h0;
    failures = 0;
    n_checks = 0;
    nrise = 0;
    cyc(4);
    nrst <= 1'h1;
    bus(1'h0, ADDR_CTRL_ONE, 32'h0, d);
    chk(d, 32'h0);
    for (int i = 0; i < 12; i++) begin
      bus(1'h0, ra[i], 32'h0, d);
      chk(d, 32'h0);
      wr(ra[i], 32'hFFFF_FFFF);
      bus(1'h0, ra[i], 32'h0, d);
      chk(d, {16'h0000, rm[i]});
      wr(ra[i], 32'h0000_0000);
    end
    wr(8'h40, 32'hFFFF_FFFF);
    bus(1'h0, 8'h40, 32'h0, d);
    chk(d, 32'h0);
    wr(ADDR_CTRL_TWO, 32'h0000_0008);
    wr(ADDR_ON_TIME_A, 32'h0000_0005);
    // The counter runs from 0 up to the on-time value inclusive, so the pin stays high one cycle longer.
    pulse(GO, 8'h01, 8'h01, 9'h000, 0, lat1, wid);
    chk(32'(wid), 32'h6);
    pulse(GO, 8'h00, 8'h00, 9'h000, 0, lat, wid);
    chk(32'(lat), 32'(lat1));
    pulse(GO, 8'h09, 8'h09, 9'h000, 0, lat, wid);
    chk(32'(lat), 32'(lat1 + 8));
    pulse(GO, 8'h15, 8'h01, 9'h000, 0, lat, wid);
    chk(32'(lat), 32'(lat1 + 20));
    wr(ADDR_ON_TIME_B, 32'h0000_0007);
    pulse(GO | 32'h0000_0008, 8'h01, 8'h01, 9'h000, 0, lat, wid);
    chk(32'(wid), 32'h8);
    wr(ADDR_ON_TIME_A, 32'h0000_003C);
    pulse(GO, 8'h01, 8'h01, 9'h004, 10, lat, wid);
    chk(32'(wid >= 11 && wid <= 16), 32'h1);
    bus(1'h0, ADDR_CAPTURE, 32'h0, d);
    chk(32'(d[10:0] >= 10 && d[10:0] <= 18), 32'h1);
    wr(ADDR_CAPTURE, 32'h0000_8000);
    pulse(GO, 8'h01, 8'h01, 9'h080, 30, lat, wid);
    chk(32'(wid), 32'h3D);
    bus(1'h0, ADDR_CAPTURE, 32'h0, d);
    chk(32'(d[10:0] >= 30 && d[10:0] <= 38), 32'h1);
    wr(ADDR_TIMEOUT, 32'h0000_00C8);
    wr(ADDR_ON_TIME_A, 32'h0000_0004);
    wr(ADDR_DELAY, 32'h0000_0003);
    wr(ADDR_CTRL_ONE, GO | REP);
    base = nrise;
    for (int i = 0; i < 4; i++) begin
      cyc(40);
      cmd <= 9'h001;
      cyc(5);
      cmd <= 9'h000;
    end
    cyc(40);
    chk(32'(nrise - base), 32'h5);
    wr(ADDR_CTRL_ONE, EN);
    wr(ADDR_TIMEOUT, 32'h0000_000A);
    wr(ADDR_CTRL_ONE, GO | REP);
    wr(ADDR_CTRL_ONE, GO);
    base = nrise;
    cyc(150);
    chk(32'(nrise - base >= 4 && nrise - base <= 10), 32'h1);
    wr(ADDR_CTRL_ONE, EN);
    wr(ADDR_CTRL_ONE, GO);
    base = nrise;
    for (int i = 0; i < 3; i++) begin
      cyc(30);
      cmd <= 9'h001;
      cyc(5);
      cmd <= 9'h000;
    end
    cyc(30);
    chk(32'(nrise - base), 32'h1);
    wr(ADDR_CTRL_ONE, EN);
    cmd <= 9'h002;
    cyc(6);
    bus(1'h0, ADDR_CTRL_ONE, 32'h0, d);
    chk(d & 32'h0000_0008, 32'h0000_0008);
    cmd <= 9'h000;
    wr(ADDR_ON_TIME_A, 32'h0000_07FF);
    wr(ADDR_CTRL_ONE, GO);
    cyc(20);
    cmd <= 9'h040;
    cyc(6);
    bus(1'h0, ADDR_CTRL_ONE, 32'h0, d);
    chk(d & 32'h0000_0040, 32'h0);
    chk({31'h0, pin}, 32'h0);
    cmd <= 9'h000;
    wr(ADDR_CTRL_ONE, GO | 32'h0000_0010);
    cmd <= 9'h100;
    cyc(6);
    bus(1'h0, ADDR_CTRL_ONE, 32'h0, d);
    chk(d & 32'h0000_0052, 32'h0000_0012);
    cmd <= 9'h000;
    // A slow front end here shows that routing follows the level, not a fixed delay.
    lag <= 4'h3;
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CTRL_TWO, 32'h0000_000C | (32'(s) << 4));
      cmd <= {1'h0, 8'h01 << s};
      cyc(10);
      chk({31'h0, route}, 32'h1);
      cmd <= {1'h0, ~(8'h01 << s)};
      cyc(10);
      chk({31'h0, route}, 32'h0);
    end
    conclude();
  end

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule
